// file: dv/sdt_panel_model.sv
`timescale 1ns/1ps
// behavioural serial panel: answers reads, catches written bits
module sdt_panel_model (
  // clock
  input wire logic clk,
  // pins from the device
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic oe,
  input wire logic dout,
  // bench controls: reply bit and cycles after select before it is driven
  input wire logic reply,
  input wire logic [3:0] delay,
  // answer to the device and last bit caught
  output logic din,
  output logic got_bit
);
  logic [7:0] sel_cycles = 8'h00;
  logic sclk_prev = 1'b1;
  logic toggle = 1'b0;
  logic got_reg = 1'b1;

  // count selected cycles; a released line toggles so a stale value never passes
  always @(posedge clk) begin
    sel_cycles <= cs_n ? 8'h00 : sel_cycles + 8'h01;
    sclk_prev <= sclk;
    toggle <= ~toggle;
  end

  // catch write data on the rising serial clock while selected
  always @(posedge clk) begin
    if (!cs_n && oe && sclk && !sclk_prev) begin
      got_reg <= dout;
    end
  end

  // reply held only inside the select window, after the chosen delay
  assign din = (!cs_n && !oe && sel_cycles >= {4'h0, delay}) ? reply : toggle;
  assign got_bit = got_reg;
endmodule : sdt_panel_model

// file: dv/tb_sdt_serial_timing.sv
`timescale 1ns/1ps
module tb_sdt_serial_timing;
  logic mclk, rst_n, req, acc_wr, acc_sel, acc_bit, reply;
  logic [1:0] mode;
  logic [7:0] div, off;
  logic [7:0] cnt [0:10];
  logic [3:0] delay;
  logic acc_ack, busy, rvalid, rbit, sclk, cs_n, rsel, dout, oe, din, sd_in, got_bit;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // three-wire join: the device wins the line while it drives
  assign sd_in = oe ? dout : din;

  sdt_serial_timing sdt_serial_timing_inst (
    .MCLK(mclk), .RST_N(rst_n), .WIRE_MODE(mode),
    .READ_PERIOD_COUNT(cnt[0]), .WRITE_PERIOD_COUNT(cnt[1]),
    .READ_CLOCK_RISE_COUNT(cnt[2]), .READ_CLOCK_FALL_COUNT(cnt[3]),
    .WRITE_CLOCK_RISE_COUNT(cnt[4]), .WRITE_CLOCK_FALL_COUNT(cnt[5]),
    .INTERFACE_PERIOD_DIVIDER(div), .SERIAL_CLOCK_OFFSET_COUNT(off),
    .SELECT_LINE_RISE_COUNT(cnt[6]), .SELECT_LINE_FALL_COUNT(cnt[7]),
    .CHIP_SELECT_RISE_COUNT(cnt[8]), .CHIP_SELECT_FALL_COUNT(cnt[9]),
    .READ_SAMPLE_COUNT(cnt[10]),
    .ACCESS_REQ(req), .ACCESS_WRITE(acc_wr), .ACCESS_REGISTER_SELECT(acc_sel),
    .ACCESS_WRITE_BIT(acc_bit), .ACCESS_ACK(acc_ack), .ACCESS_BUSY(busy),
    .READ_VALID(rvalid), .READ_BIT(rbit), .SERIAL_CLOCK(sclk), .CHIP_SELECT_N(cs_n),
    .REGISTER_SELECT(rsel), .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OUTPUT_ENABLE(oe),
    .SERIAL_DATA_IN(sd_in)
  );

  sdt_panel_model sdt_panel_model_inst (
    .clk(mclk), .sclk(sclk), .cs_n(cs_n), .oe(oe), .dout(dout),
    .reply(reply), .delay(delay), .din(din), .got_bit(got_bit)
  );

  // clock at 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ceiling division, a zero divider counting as one
  function automatic int cdiv(input int x, input int d);
    int dd;
    dd = (d == 0) ? 1 : d;
    return (x + dd - 1) / dd;
  endfunction : cdiv

  // whole interface periods in core cycles for count slot i
  function automatic int w(input int i);
    return 2 * cdiv(cnt[i], div);
  endfunction : w

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // wait for the acknowledge under a bound, returning cycles waited
  task automatic wait_ack(output int n, input int lim);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (acc_ack !== 1'b1 && n < lim);
  endtask : wait_ack

  // one access, every pin compared cycle by cycle, data out on writes only; pins lag the counter by one cycle
  task automatic access(input logic wr, input logic b);
    int p, lo, hi, n;
    logic e;
    p = wr ? w(1) : w(0);
    lo = cdiv(2 * (wr ? cnt[4] : cnt[2]), div) + 2 * cdiv(off, div);
    hi = cdiv(2 * (wr ? cnt[5] : cnt[3]), div) + 2 * cdiv(off, div);
    @(posedge mclk);
    req <= 1'b1;
    acc_wr <= wr;
    acc_bit <= b;
    reply <= b;
    wait_ack(n, 20);
    check("ack_latency", n, 2);
    @(posedge mclk);
    req <= 1'b0;
    for (int t = 0; t <= p; t++) begin
      @(negedge mclk);
      check("busy", busy, t <= p - 2);
      check("serial_clock", sclk, !(t < p && t >= lo && t < hi));
      check("chip_select_n", cs_n, !(t < p && t >= w(8) && t < w(9)));
      e = (t < p && (mode == 2'b11 || (mode == 2'b10 && t >= w(6) && t < w(7)))) ? acc_sel : 1'b0;
      check("register_select", rsel, e);
      check("output_enable", oe, wr && t < p);
      if (wr && t < p) check("data_out", dout, b);
      check("read_valid", rvalid, !wr && t == w(10));
      if (!wr && t == w(10)) check("read_bit", rbit, b);
    end
    if (wr) check("panel_bit", got_bit, b);
  endtask : access

  // main sequence
  initial begin
    int n;
    rst_n = 1'b0;
    req = 1'b0;
    acc_wr = 1'b0;
    acc_sel = 1'b0;
    acc_bit = 1'b0;
    reply = 1'b0;
    mode = 2'b00;
    div = 8'h01;
    off = 8'h01;
    delay = 4'h3;
    cnt = '{8'h0B, 8'h06, 8'h02, 8'h06, 8'h01, 8'h04, 8'h01, 8'h05, 8'h01, 8'h09, 8'h07};
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check("reset_clock", sclk, 1'b1);
    check("reset_select", cs_n, 1'b1);
    check("reset_busy", busy, 1'b0);
    check("reset_enable", oe, 1'b0);
    // divider one, three and zero; every wiring variant, writes and reads
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      div <= (k == 1) ? 8'h03 : ((k == 0) ? 8'h01 : 8'h00);
      off <= (k == 1) ? 8'h00 : 8'h01;
      delay <= (k == 1) ? 4'h0 : 4'h3;
      for (int m = 0; m < 4; m++) begin
        @(posedge mclk);
        mode <= m[1:0];
        acc_sel <= m[0] ^ ~k[0];
        access(1'b1, m[0]);
        access(1'b0, ~m[0]);
      end
    end
    // back-to-back writes: the held request is refused until the last cycle
    @(posedge mclk);
    req <= 1'b1;
    acc_wr <= 1'b1;
    wait_ack(n, 20);
    wait_ack(n, 40);
    check("back_to_back", n, w(1));
    @(posedge mclk);
    req <= 1'b0;
    repeat (20) @(negedge mclk);
    check("busy_end", busy, 1'b0);
    summarize();
  end

  // cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
endmodule : tb_sdt_serial_timing

// file: rtl/sdt_defines.svh
`ifndef SDT_DEFINES_SVH
`define SDT_DEFINES_SVH

// width of every programmed count
`define SDT_CNT_W 8
// width of an edge time counted in MCLK cycles from the start of an access
`define SDT_TIME_W 11
// core clock period and display interface clock period, in picoseconds
`define SDT_MCLK_PERIOD_PS 4000
`define SDT_IF_CLK_PERIOD_PS 8000
// MCLK cycles per half interface clock period, rounded up and never below one
`define SDT_HALF_IF_CYC ((`SDT_IF_CLK_PERIOD_PS / 2 + `SDT_MCLK_PERIOD_PS - 1) / `SDT_MCLK_PERIOD_PS)
// a divider of zero is taken as this value
`define SDT_DIV_MIN 8'h01
// shortest access in MCLK cycles, used when a zero period is programmed
`define SDT_PERIOD_MIN 11'h001
// level of the serial clock and chip-select pins while no access runs
`define SDT_SCLK_IDLE 1'b1
`define SDT_CS_N_IDLE 1'b1

`endif

// file: rtl/sdt_edge_calc.sv
`timescale 1ns/1ps
`include "sdt_defines.svh"
module sdt_edge_calc (
  // programmed counts in, edge times out
  sdt_edge_if.calc edge_bus
);

  // ceiling of num over div, with a zero divider taken as one
  function automatic logic [9:0] sdt_ceil_div(input logic [9:0] num, input logic [`SDT_CNT_W-1:0] div);
    logic [9:0] d;
    d = (div == 8'h00) ? {2'h0, `SDT_DIV_MIN} : {2'h0, div};
    sdt_ceil_div = (num + d - 10'h001) / d;
  endfunction : sdt_ceil_div

  // half-period resolution: ceil(2 x count / divider) half periods
  function automatic logic [`SDT_TIME_W-1:0] sdt_half(input logic [`SDT_CNT_W-1:0] cnt,
                                                      input logic [`SDT_CNT_W-1:0] div);
    logic [9:0] h;
    h = sdt_ceil_div({1'b0, cnt, 1'b0}, div);
    sdt_half = 11'({1'b0, h} * `SDT_HALF_IF_CYC);
  endfunction : sdt_half

  // whole-period resolution: ceil(count / divider) periods, two halves each
  function automatic logic [`SDT_TIME_W-1:0] sdt_whole(input logic [`SDT_CNT_W-1:0] cnt,
                                                       input logic [`SDT_CNT_W-1:0] div);
    logic [9:0] w;
    w = sdt_ceil_div({2'h0, cnt}, div);
    sdt_whole = 11'({w, 1'b0} * `SDT_HALF_IF_CYC);
  endfunction : sdt_whole

  sdt_pkg::sdt_dir_cfg_t dir;
  logic [`SDT_CNT_W-1:0] div;
  logic [`SDT_TIME_W-1:0] per;

  // direction picks its own period and clock counts
  assign dir = edge_bus.is_write ? edge_bus.cfg.wr : edge_bus.cfg.rd;
  assign div = edge_bus.cfg.interface_period_divider;
  assign per = sdt_whole(dir.period, div);

  // edge table; a zero period still lasts one cycle so the sequencer always ends
  always_comb begin
    edge_bus.times.period = (per == 11'h000) ? `SDT_PERIOD_MIN : per;
    edge_bus.times.clk_fall = sdt_half(dir.clock_fall_count, div);
    edge_bus.times.clk_rise = sdt_half(dir.clock_rise_count, div);
    edge_bus.times.clk_offset = sdt_whole(edge_bus.cfg.serial_clock_offset_count, div);
    edge_bus.times.sel_rise = sdt_whole(edge_bus.cfg.select_line_rise_count, div);
    edge_bus.times.sel_fall = sdt_whole(edge_bus.cfg.select_line_fall_count, div);
    edge_bus.times.cs_rise = sdt_whole(edge_bus.cfg.chip_select_rise_count, div);
    edge_bus.times.cs_fall = sdt_whole(edge_bus.cfg.chip_select_fall_count, div);
    edge_bus.times.rd_sample = sdt_whole(edge_bus.cfg.read_sample_count, div);
  end

endmodule : sdt_edge_calc

// file: rtl/sdt_edge_if.sv
`timescale 1ns/1ps
interface sdt_edge_if;
  sdt_pkg::sdt_cfg_t cfg;
  logic is_write;
  sdt_pkg::sdt_times_t times;

  modport calc (input cfg, input is_write, output times);
  modport user (output cfg, output is_write, input times);
endinterface : sdt_edge_if

// file: rtl/sdt_pkg.sv
package sdt_pkg;
  `include "sdt_defines.svh"

  // serial port wiring variants
  typedef enum logic [1:0] {
    SDT_WIRE3 = 2'b00,
    SDT_WIRE4 = 2'b01,
    SDT_WIRE5_CLK = 2'b10,
    SDT_WIRE5_CS = 2'b11
  } sdt_mode_t;

  // access sequencer states
  typedef enum logic {
    SDT_IDLE = 1'b0,
    SDT_RUN = 1'b1
  } sdt_state_t;

  // counts that differ between reads and writes
  typedef struct packed {
    logic [`SDT_CNT_W-1:0] period;
    logic [`SDT_CNT_W-1:0] clock_fall_count;
    logic [`SDT_CNT_W-1:0] clock_rise_count;
  } sdt_dir_cfg_t;

  // whole programmed timing set
  typedef struct packed {
    sdt_dir_cfg_t rd;
    sdt_dir_cfg_t wr;
    logic [`SDT_CNT_W-1:0] interface_period_divider;
    logic [`SDT_CNT_W-1:0] serial_clock_offset_count;
    logic [`SDT_CNT_W-1:0] select_line_rise_count;
    logic [`SDT_CNT_W-1:0] select_line_fall_count;
    logic [`SDT_CNT_W-1:0] chip_select_rise_count;
    logic [`SDT_CNT_W-1:0] chip_select_fall_count;
    logic [`SDT_CNT_W-1:0] read_sample_count;
  } sdt_cfg_t;

  // edge times in MCLK cycles from the access start
  typedef struct packed {
    logic [`SDT_TIME_W-1:0] period;
    logic [`SDT_TIME_W-1:0] clk_fall;
    logic [`SDT_TIME_W-1:0] clk_rise;
    logic [`SDT_TIME_W-1:0] clk_offset;
    logic [`SDT_TIME_W-1:0] sel_rise;
    logic [`SDT_TIME_W-1:0] sel_fall;
    logic [`SDT_TIME_W-1:0] cs_rise;
    logic [`SDT_TIME_W-1:0] cs_fall;
    logic [`SDT_TIME_W-1:0] rd_sample;
  } sdt_times_t;
endpackage : sdt_pkg

// file: rtl/sdt_serial_timing.sv
`timescale 1ns/1ps
`include "sdt_defines.svh"
// Functional notes
// - Read and write accesses each last their own programmed period.
// - Read clock low edge at half periods times ceil(2 x rise count / divider).
// - Read clock high edge at half periods times ceil(2 x fall count / divider).
// - Write clock low edge placed the same way from write rise count.
// - Write clock high edge placed the same way from write fall count.
// - Read clock low for down minus up, high for the remaining period.
// - Write clock low for down minus up, high for the remaining period.
// - Serial clock offset is whole periods times ceil(offset count / divider).
// - Select and chip-select edges at whole periods times ceil(count / divider).
// - Write data driven from cycle start and held to the period end.
// - Controls valid from cycle start and held until the period end.
// - Three-wire, four-wire and two five-wire variants are supported.
// - Five-wire type 1 frames select by clock, type 2 by chip-select.
// - Separate data in and out lines plus an output enable for three-wire.
module sdt_serial_timing (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // configuration
  input wire logic [1:0] WIRE_MODE,
  input wire logic [7:0] READ_PERIOD_COUNT,
  input wire logic [7:0] WRITE_PERIOD_COUNT,
  input wire logic [7:0] READ_CLOCK_FALL_COUNT,
  input wire logic [7:0] READ_CLOCK_RISE_COUNT,
  input wire logic [7:0] WRITE_CLOCK_FALL_COUNT,
  input wire logic [7:0] WRITE_CLOCK_RISE_COUNT,
  input wire logic [7:0] INTERFACE_PERIOD_DIVIDER,
  input wire logic [7:0] SERIAL_CLOCK_OFFSET_COUNT,
  input wire logic [7:0] SELECT_LINE_RISE_COUNT,
  input wire logic [7:0] SELECT_LINE_FALL_COUNT,
  input wire logic [7:0] CHIP_SELECT_RISE_COUNT,
  input wire logic [7:0] CHIP_SELECT_FALL_COUNT,
  input wire logic [7:0] READ_SAMPLE_COUNT,
  // access request and answer
  input wire logic ACCESS_REQ,
  input wire logic ACCESS_WRITE,
  input wire logic ACCESS_REGISTER_SELECT,
  input wire logic ACCESS_WRITE_BIT,
  output logic ACCESS_ACK,
  output logic ACCESS_BUSY,
  output logic READ_VALID,
  output logic READ_BIT,
  // serial pins
  output logic SERIAL_CLOCK,
  output logic CHIP_SELECT_N,
  output logic REGISTER_SELECT,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUTPUT_ENABLE,
  input wire logic SERIAL_DATA_IN
);

  sdt_edge_if edge_bus ();

  sdt_pkg::sdt_state_t state_reg;
  sdt_pkg::sdt_state_t state_next;
  sdt_pkg::sdt_times_t tm_reg;
  sdt_pkg::sdt_mode_t mode_reg;
  logic [`SDT_TIME_W-1:0] t_reg;
  logic [`SDT_TIME_W-1:0] t_next;
  logic wr_reg;
  logic sel_val_reg;
  logic dout_reg;
  logic din_meta_reg;
  logic din_sync_reg;
  logic last;
  logic take;
  logic run;
  logic clk_low_win;
  logic cs_win;
  logic sel_win;
  logic sample_hit;

  // true while t lies in [a + off, b + off); widened so the sum cannot wrap
  function automatic logic sdt_in_win(input logic [`SDT_TIME_W-1:0] t, input logic [`SDT_TIME_W-1:0] a,
                                      input logic [`SDT_TIME_W-1:0] b, input logic [`SDT_TIME_W-1:0] off);
    logic [`SDT_TIME_W:0] lo;
    logic [`SDT_TIME_W:0] hi;
    lo = {1'b0, a} + {1'b0, off};
    hi = {1'b0, b} + {1'b0, off};
    sdt_in_win = ({1'b0, t} >= lo) && ({1'b0, t} < hi);
  endfunction : sdt_in_win

  // the edge table is worked out for the direction being requested
  assign edge_bus.is_write = ACCESS_WRITE;
  assign edge_bus.cfg = '{
    rd: '{READ_PERIOD_COUNT, READ_CLOCK_FALL_COUNT, READ_CLOCK_RISE_COUNT},
    wr: '{WRITE_PERIOD_COUNT, WRITE_CLOCK_FALL_COUNT, WRITE_CLOCK_RISE_COUNT},
    interface_period_divider: INTERFACE_PERIOD_DIVIDER,
    serial_clock_offset_count: SERIAL_CLOCK_OFFSET_COUNT,
    select_line_rise_count: SELECT_LINE_RISE_COUNT,
    select_line_fall_count: SELECT_LINE_FALL_COUNT,
    chip_select_rise_count: CHIP_SELECT_RISE_COUNT,
    chip_select_fall_count: CHIP_SELECT_FALL_COUNT,
    read_sample_count: READ_SAMPLE_COUNT
  };

  sdt_edge_calc sdt_edge_calc_inst (
    .edge_bus (edge_bus.calc)
  );

  // sequencer decisions; a request in the last cycle starts the next access back to back
  assign run = (state_reg == sdt_pkg::SDT_RUN);
  assign last = run && (t_reg == tm_reg.period - 11'h001);
  assign take = ACCESS_REQ && (!run || last);

  // next state, plain case with a safe default
  always_comb begin
    case (state_reg)
      sdt_pkg::SDT_IDLE: state_next = take ? sdt_pkg::SDT_RUN : sdt_pkg::SDT_IDLE;
      sdt_pkg::SDT_RUN: state_next = (last && !take) ? sdt_pkg::SDT_IDLE : sdt_pkg::SDT_RUN;
      default: state_next = sdt_pkg::SDT_IDLE;
    endcase
  end

  // cycle counter restarts at every access start
  always_comb begin
    if (take) begin
      t_next = '0;
    end else if (run) begin
      t_next = t_reg + 11'h001;
    end else begin
      t_next = t_reg;
    end
  end

  // state and position within the access
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= sdt_pkg::SDT_IDLE;
      t_reg <= '0;
    end else begin
      state_reg <= state_next;
      t_reg <= t_next;
    end
  end

  // per-access values frozen at the start so config changes cannot tear a cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tm_reg <= '0;
      mode_reg <= sdt_pkg::SDT_WIRE3;
      wr_reg <= 1'b0;
      sel_val_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else if (take) begin
      tm_reg <= edge_bus.times;
      mode_reg <= sdt_pkg::sdt_mode_t'(WIRE_MODE);
      wr_reg <= ACCESS_WRITE;
      sel_val_reg <= ACCESS_REGISTER_SELECT;
      dout_reg <= ACCESS_WRITE_BIT;
    end
  end

  // edge windows of the running access
  assign clk_low_win = run && sdt_in_win(t_reg, tm_reg.clk_rise, tm_reg.clk_fall, tm_reg.clk_offset);
  assign cs_win = run && sdt_in_win(t_reg, tm_reg.cs_rise, tm_reg.cs_fall, '0);
  assign sel_win = run && sdt_in_win(t_reg, tm_reg.sel_rise, tm_reg.sel_fall, '0);
  assign sample_hit = run && !wr_reg && (t_reg == tm_reg.rd_sample);

  // serial clock and chip-select pins, all registered
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SERIAL_CLOCK <= `SDT_SCLK_IDLE;
      CHIP_SELECT_N <= `SDT_CS_N_IDLE;
    end else begin
      SERIAL_CLOCK <= !clk_low_win;
      CHIP_SELECT_N <= !cs_win;
    end
  end

  // register select: type 1 is framed for the clock, type 2 spans the whole cycle around chip-select
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REGISTER_SELECT <= 1'b0;
    end else begin
      case (mode_reg)
        sdt_pkg::SDT_WIRE5_CLK: REGISTER_SELECT <= sel_win && sel_val_reg;
        sdt_pkg::SDT_WIRE5_CS: REGISTER_SELECT <= run && sel_val_reg;
        default: REGISTER_SELECT <= 1'b0;
      endcase
    end
  end

  // write data and its enable stand from the cycle start to the period end
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OUTPUT_ENABLE <= 1'b0;
    end else begin
      SERIAL_DATA_OUT <= run && wr_reg && dout_reg;
      SERIAL_DATA_OUTPUT_ENABLE <= run && wr_reg;
    end
  end

  // input pin synchroniser; the first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      din_meta_reg <= SERIAL_DATA_IN;
      din_sync_reg <= din_meta_reg;
    end
  end

  // read capture; the panel must have data settled two cycles earlier to cover the synchroniser
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      READ_VALID <= 1'b0;
      READ_BIT <= 1'b0;
    end else begin
      READ_VALID <= sample_hit;
      if (sample_hit) begin
        READ_BIT <= din_sync_reg;
      end
    end
  end

  // request handshake
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ACCESS_ACK <= 1'b0;
      ACCESS_BUSY <= 1'b0;
    end else begin
      ACCESS_ACK <= take;
      ACCESS_BUSY <= (state_next == sdt_pkg::SDT_RUN);
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_start;
    take;
  endsequence

  sequence s_last_idle;
    last && !take;
  endsequence

  a_start_restart: assert property (s_start |=> (t_reg == 11'h000) && run)
    else $error("counter did not restart at access start");

  a_period_end: assert property (s_last_idle |=> !run && !ACCESS_BUSY)
    else $error("access did not end after its period");

  a_period_bound: assert property (run |-> t_reg < tm_reg.period)
    else $error("cycle counter ran past the period");

  a_clock_low: assert property (clk_low_win |=> !SERIAL_CLOCK)
    else $error("serial clock not low inside its window");

  a_clock_high: assert property (run && !clk_low_win |=> SERIAL_CLOCK)
    else $error("serial clock not high outside its window");

  a_clock_idle: assert property (!run ##1 !run |-> SERIAL_CLOCK && CHIP_SELECT_N)
    else $error("pins not idle between accesses");

  a_cs_window: assert property (run && (t_reg == tm_reg.cs_rise) && (tm_reg.cs_rise < tm_reg.cs_fall)
                                |=> !CHIP_SELECT_N)
    else $error("chip select missed its assert edge");

  a_write_data: assert property (run && wr_reg && !take ##1 run && !take |=> $stable(SERIAL_DATA_OUT))
    else $error("write data changed inside a write cycle");

  a_ctrl_hold: assert property (run && !take |=> $stable(wr_reg) && $stable(sel_val_reg))
    else $error("control value changed inside a cycle");

  a_read_sample: assert property (sample_hit ##1 1'b1 |-> READ_VALID && (READ_BIT == $past(din_sync_reg)))
    else $error("read sample missing or wrong");

  a_oe_read: assert property (run && !wr_reg |=> !SERIAL_DATA_OUTPUT_ENABLE)
    else $error("data line driven during a read");

  a_rs_mode: assert property ((mode_reg == sdt_pkg::SDT_WIRE3 || mode_reg == sdt_pkg::SDT_WIRE4)
                              |=> !REGISTER_SELECT)
    else $error("select line active in a mode without it");

  // a running write owns the shared data line
  sequence s_write_run;
    run && wr_reg;
  endsequence

  a_oe_write: assert property (s_write_run |=> SERIAL_DATA_OUTPUT_ENABLE)
    else $error("data line not driven during a write");

  a_ack_pulse: assert property (s_start |=> ACCESS_ACK && ACCESS_BUSY)
    else $error("taken request not answered");

  a_sel_whole: assert property (run && !take && (mode_reg == sdt_pkg::SDT_WIRE5_CS)
                                |=> (REGISTER_SELECT == sel_val_reg))
    else $error("type 2 select line lost its value");

endmodule : sdt_serial_timing
